// [src/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;
    // register byte offsets
    localparam logic [7:0] CSR_OFFSET = 8'h00;
    localparam logic [7:0] DATA_BASE_OFFSET = 8'h04;
    localparam logic [7:0] DATA_LAST_OFFSET = 8'h10;
    localparam logic [7:0] EVT_STATUS_OFFSET = 8'h14;
    localparam logic [7:0] EVT_MASK_OFFSET = 8'h18;

    // control/status field positions
    localparam int FLAG_BIT = 15;
    localparam int IRQ_EN_BIT = 14;
    localparam int START_BIT = 13;
    localparam int ROUTE_BIT = 12;
    localparam int CLK_SEL_LSB = 6;
    localparam int MODE_LSB = 4;
    localparam int CHAN_LSB = 0;
    localparam int RESULT_LSB = 6;
    localparam int RESULT_W = 10;
    localparam int CHAN_COUNT = 4;

    // event status / mask layout
    localparam int EVT_W = 2;
    localparam int EVT_PASS_BIT = 0;
    localparam int EVT_CHAN_BIT = 1;

    // reset values
    localparam logic FLAG_RESET = 1'b0;
    localparam logic IRQ_EN_RESET = 1'b0;
    localparam logic START_RESET = 1'b0;
    localparam logic ROUTE_RESET = 1'b0;
    localparam logic [1:0] CLK_SEL_RESET = 2'h1;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [1:0] CHAN_RESET = 2'h0;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
    localparam logic [9:0] RESULT_RESET = 10'h000;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_PROHIBITED = 2'h1,
        MODE_MULTI = 2'h2,
        MODE_SCAN = 2'h3
    } conv_mode_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_ISSUE = 2'h1,
        SEQ_WAIT = 2'h3,
        SEQ_HOLD = 2'h2
    } seq_state_t;

    // request to the converter core
    typedef struct packed {
        logic start;
        logic [1:0] channel;
    } core_req_t;

    // answer from the converter core
    typedef struct packed {
        logic done;
        logic [9:0] result;
    } core_rsp_t;

    // sequencer report to the register file
    typedef struct packed {
        logic valid;
        logic [1:0] channel;
        logic [9:0] result;
        logic pass_done;
        logic finished;
    } seq_event_t;
endpackage : adc_ctrl_pkg

// [src/conv_sequencer.sv]
`timescale 1ns/100ps
module conv_sequencer (
    input logic clk,
    input logic rst_n,
    input logic enable,
    input adc_ctrl_pkg::conv_mode_t mode,
    input logic [1:0] chan_sel,
    output adc_ctrl_pkg::core_req_t core_req,
    input adc_ctrl_pkg::core_rsp_t core_rsp,
    output adc_ctrl_pkg::seq_event_t evt
);
    typedef struct packed {
        adc_ctrl_pkg::seq_state_t st;
        adc_ctrl_pkg::core_req_t req;
        adc_ctrl_pkg::seq_event_t evt;
    } seq_t;

    seq_t s;
    seq_t next_s;
    logic single;
    logic last_chan;

    // single (and the prohibited code) convert just the selected channel
    assign single = (mode == adc_ctrl_pkg::MODE_SINGLE) ||
                    (mode == adc_ctrl_pkg::MODE_PROHIBITED);
    assign last_chan = single || (s.req.channel == chan_sel);

    // channel stepping and pass completion
    always_comb begin
        next_s = s;
        next_s.req.start = 1'b0;
        next_s.evt = '0;
        case (s.st)
            adc_ctrl_pkg::SEQ_IDLE: begin
                if (enable) begin
                    next_s.req.start = 1'b1;
                    next_s.req.channel = single ? chan_sel : 2'h0;
                    next_s.st = adc_ctrl_pkg::SEQ_ISSUE;
                end
            end
            adc_ctrl_pkg::SEQ_ISSUE: begin
                next_s.st = adc_ctrl_pkg::SEQ_WAIT;
            end
            adc_ctrl_pkg::SEQ_WAIT: begin
                if (core_rsp.done) begin
                    next_s.evt.valid = 1'b1;
                    next_s.evt.channel = s.req.channel;
                    next_s.evt.result = core_rsp.result;
                    if (!last_chan) begin
                        next_s.req.start = 1'b1;
                        next_s.req.channel = s.req.channel + 2'h1;
                        next_s.st = adc_ctrl_pkg::SEQ_ISSUE;
                    end else if (mode == adc_ctrl_pkg::MODE_SCAN) begin
                        next_s.evt.pass_done = 1'b1;
                        next_s.req.start = 1'b1;
                        next_s.req.channel = 2'h0;
                        next_s.st = adc_ctrl_pkg::SEQ_ISSUE;
                    end else begin
                        next_s.evt.pass_done = 1'b1;
                        next_s.evt.finished = 1'b1;
                        next_s.st = adc_ctrl_pkg::SEQ_HOLD;
                    end
                end
            end
            default: begin
                // wait for the start bit to drop before rearming
                if (!enable) begin
                    next_s.st = adc_ctrl_pkg::SEQ_IDLE;
                end
            end
        endcase
        // start bit low halts any conversion at once
        if (!enable) begin
            next_s.st = adc_ctrl_pkg::SEQ_IDLE;
            next_s.req.start = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign core_req = s.req;
    assign evt = s.evt;
endmodule : conv_sequencer

// [src/adc_control_status_upper.sv]
// Behaviour
// - single mode: flag set when conversion ends
// - multi/scan: flag set after full pass
// - flag cleared by writing 0 after reading 1
// - result read by DMA clears flag
// - writing 1 to flag is ignored
// - request raised only with irq enable set
// - start 1 begins, 0 stops conversion
// - start bit reads 1 while converting
// - single mode clears start when done
// - multi mode clears start after pass
// - scan repeats until software, reset, standby
// - route bit picks interrupt or DMA request
// - bits 11 to 8 read zero
// - result stored in bits 15:6
`timescale 1ns/100ps
module adc_control_status_upper (
    input logic CORE_CLK,
    input logic RESET_N,
    input logic PSEL,
    input logic PENABLE,
    input logic PWRITE,
    input logic [7:0] PADDR,
    input logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input logic STANDBY,
    output adc_ctrl_pkg::core_req_t CORE_REQ,
    input adc_ctrl_pkg::core_rsp_t CORE_RSP,
    output logic CONV_END_IRQ,
    output logic DMA_REQUEST,
    output logic IRQ
);
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_CSR = 3'h1,
        SEL_DATA = 3'h2,
        SEL_EVT = 3'h3,
        SEL_MASK = 3'h4
    } reg_sel_t;

    typedef struct packed {
        logic flag;
        logic flag_seen;
        logic irq_en;
        logic start;
        logic route;
        logic [1:0] clk_sel;
        adc_ctrl_pkg::conv_mode_t mode;
        logic [1:0] chan;
        logic [adc_ctrl_pkg::CHAN_COUNT-1:0][9:0] result;
        logic [adc_ctrl_pkg::EVT_W-1:0] evt_status;
        logic [adc_ctrl_pkg::EVT_W-1:0] evt_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic conv_irq;
        logic dma_req;
        logic irq;
    } regs_t;

    regs_t s;
    regs_t next_s;
    logic [1:0] rst_sync;
    logic rst_n;
    adc_ctrl_pkg::seq_event_t evt;
    logic commit;
    logic [1:0] data_idx;
    reg_sel_t sel;

    // address decode shared by read, write and error answer
    function automatic reg_sel_t decode(input logic [7:0] a);
        reg_sel_t r;
        r = SEL_NONE;
        if (a == adc_ctrl_pkg::CSR_OFFSET) begin
            r = SEL_CSR;
        end else if (a >= adc_ctrl_pkg::DATA_BASE_OFFSET &&
                     a <= adc_ctrl_pkg::DATA_LAST_OFFSET && a[1:0] == 2'h0) begin
            r = SEL_DATA;
        end else if (a == adc_ctrl_pkg::EVT_STATUS_OFFSET) begin
            r = SEL_EVT;
        end else if (a == adc_ctrl_pkg::EVT_MASK_OFFSET) begin
            r = SEL_MASK;
        end
        return r;
    endfunction : decode

    // read value of the control/status word
    function automatic logic [31:0] csr_word(input regs_t r);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[adc_ctrl_pkg::FLAG_BIT] = r.flag;
        w[adc_ctrl_pkg::IRQ_EN_BIT] = r.irq_en;
        w[adc_ctrl_pkg::START_BIT] = r.start;
        w[adc_ctrl_pkg::ROUTE_BIT] = r.route;
        w[adc_ctrl_pkg::CLK_SEL_LSB +: 2] = r.clk_sel;
        w[adc_ctrl_pkg::MODE_LSB +: 2] = r.mode;
        w[adc_ctrl_pkg::CHAN_LSB +: 2] = r.chan;
        return w;
    endfunction : csr_word

    // reset release through two flops
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // channel sequencer driving the converter core
    conv_sequencer conv_sequencer_i (
        .clk(CORE_CLK),
        .rst_n(rst_n),
        .enable(s.start),
        .mode(s.mode),
        .chan_sel(s.chan),
        .core_req(CORE_REQ),
        .core_rsp(CORE_RSP),
        .evt(evt)
    );

    assign sel = decode(PADDR);
    assign commit = PSEL && PENABLE && s.pready;
    assign data_idx = 2'((PADDR - adc_ctrl_pkg::DATA_BASE_OFFSET) >> 2);

    // bus answer, register updates and event flags
    always_comb begin
        next_s = s;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;

        // access phase: answer one cycle later with registered data
        if (PSEL && PENABLE && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.pslverr = (sel == SEL_NONE);
            next_s.prdata = 32'h0000_0000;
            if (!PWRITE) begin
                if (sel == SEL_CSR) begin
                    next_s.prdata = csr_word(s);
                end else if (sel == SEL_DATA) begin
                    next_s.prdata[adc_ctrl_pkg::RESULT_LSB +: adc_ctrl_pkg::RESULT_W] =
                        s.result[data_idx];
                end else if (sel == SEL_EVT) begin
                    next_s.prdata[adc_ctrl_pkg::EVT_W-1:0] = s.evt_status;
                end else if (sel == SEL_MASK) begin
                    next_s.prdata[adc_ctrl_pkg::EVT_W-1:0] = s.evt_mask;
                end
            end
        end

        // hardware clears start at the end of a single or multi pass
        if (evt.finished) begin
            next_s.start = 1'b0;
        end

        // reads that carry side effects
        if (commit && !PWRITE) begin
            if (sel == SEL_CSR && s.prdata[adc_ctrl_pkg::FLAG_BIT]) begin
                next_s.flag_seen = 1'b1;
            end
            if (sel == SEL_DATA && s.route && s.flag) begin
                next_s.flag = 1'b0;
                next_s.flag_seen = 1'b0;
            end
        end

        // writes take effect at the completing edge
        if (commit && PWRITE) begin
            if (sel == SEL_CSR) begin
                if (!PWDATA[adc_ctrl_pkg::FLAG_BIT] && s.flag_seen) begin
                    next_s.flag = 1'b0;
                end
                next_s.flag_seen = 1'b0;
                next_s.irq_en = PWDATA[adc_ctrl_pkg::IRQ_EN_BIT];
                next_s.start = PWDATA[adc_ctrl_pkg::START_BIT];
                next_s.route = PWDATA[adc_ctrl_pkg::ROUTE_BIT];
                next_s.clk_sel = PWDATA[adc_ctrl_pkg::CLK_SEL_LSB +: 2];
                next_s.mode = adc_ctrl_pkg::conv_mode_t'(PWDATA[adc_ctrl_pkg::MODE_LSB +: 2]);
                next_s.chan = PWDATA[adc_ctrl_pkg::CHAN_LSB +: 2];
            end else if (sel == SEL_EVT) begin
                next_s.evt_status = s.evt_status & ~PWDATA[adc_ctrl_pkg::EVT_W-1:0];
            end else if (sel == SEL_MASK) begin
                next_s.evt_mask = PWDATA[adc_ctrl_pkg::EVT_W-1:0];
            end
        end

        // standby forces the converter idle
        if (STANDBY) begin
            next_s.start = 1'b0;
        end

        // results land in the channel's data word
        if (evt.valid) begin
            next_s.result[evt.channel] = evt.result;
            next_s.evt_status[adc_ctrl_pkg::EVT_CHAN_BIT] = 1'b1;
        end

        // hardware set last so it wins over any clear
        if (evt.pass_done) begin
            next_s.flag = 1'b1;
            next_s.evt_status[adc_ctrl_pkg::EVT_PASS_BIT] = 1'b1;
        end

        // request routing and the summary interrupt
        next_s.conv_irq = next_s.flag && next_s.irq_en && !next_s.route;
        next_s.dma_req = next_s.flag && next_s.irq_en && next_s.route;
        next_s.irq = |(next_s.evt_status & next_s.evt_mask);
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.flag <= adc_ctrl_pkg::FLAG_RESET;
            s.irq_en <= adc_ctrl_pkg::IRQ_EN_RESET;
            s.start <= adc_ctrl_pkg::START_RESET;
            s.route <= adc_ctrl_pkg::ROUTE_RESET;
            s.clk_sel <= adc_ctrl_pkg::CLK_SEL_RESET;
            s.mode <= adc_ctrl_pkg::MODE_SINGLE;
            s.chan <= adc_ctrl_pkg::CHAN_RESET;
            s.evt_status <= adc_ctrl_pkg::EVT_RESET;
            s.evt_mask <= adc_ctrl_pkg::EVT_RESET;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state flops
    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign CONV_END_IRQ = s.conv_irq;
    assign DMA_REQUEST = s.dma_req;
    assign IRQ = s.irq;
endmodule : adc_control_status_upper

// [tb/adc_csr_sva.sv]
`timescale 1ns/100ps
module adc_csr_checker (
    input logic CORE_CLK,
    input logic RESET_N,
    input logic PSEL,
    input logic PENABLE,
    input logic PWRITE,
    input logic [7:0] PADDR,
    input logic [31:0] PWDATA,
    input logic [31:0] PRDATA,
    input logic PREADY,
    input logic PSLVERR,
    input logic STANDBY,
    input adc_ctrl_pkg::core_req_t CORE_REQ,
    input adc_ctrl_pkg::core_rsp_t CORE_RSP,
    input logic CONV_END_IRQ,
    input logic DMA_REQUEST,
    input logic IRQ
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    // committed control/status write and read
    sequence csr_commit;
        PREADY && PWRITE && PADDR == adc_ctrl_pkg::CSR_OFFSET;
    endsequence
    sequence csr_read;
        PREADY && !PWRITE && PADDR == adc_ctrl_pkg::CSR_OFFSET;
    endsequence
    // start write with standby low in its commit cycle and the next one
    sequence start_cmd;
        csr_commit ##0 PWDATA[13] && !STANDBY ##1 !STANDBY;
    endsequence
    a_wait_state: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready did not follow the access phase");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_route_excl: assert property (!(CONV_END_IRQ && DMA_REQUEST))
        else $error("interrupt and dma request together");
    a_rsvd_zero: assert property (csr_read |-> PRDATA[11:8] == 4'h0)
        else $error("reserved control bits read nonzero");
    a_result_lsbs: assert property (PREADY && !PWRITE && PADDR >= adc_ctrl_pkg::DATA_BASE_OFFSET
        && PADDR <= adc_ctrl_pkg::DATA_LAST_OFFSET |-> PRDATA[5:0] == 6'h00)
        else $error("result low bits nonzero");
    a_start_req: assert property (start_cmd |-> ##1 CORE_REQ.start)
        else $error("start write gave no core request");
    a_stop_quiet: assert property (csr_commit ##0 !PWDATA[13] |-> ##2 !CORE_REQ.start [*3])
        else $error("core request after stop");
    a_standby_idle: assert property (STANDBY [*3] |-> !CORE_REQ.start)
        else $error("core request during standby");
endmodule : adc_csr_checker

// [tb/conv_core_model.sv]
`timescale 1ns/100ps
module conv_core_model (
    input logic clk,
    input logic rst_n,
    input logic [7:0] delay,
    input adc_ctrl_pkg::core_req_t req,
    output adc_ctrl_pkg::core_rsp_t rsp
);
    logic busy;
    logic [7:0] cnt;
    logic [1:0] chan;
    // one conversion at a time; idle result toggles so stale data never matches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            chan <= 2'h0;
            rsp <= '0;
        end else begin
            rsp.done <= 1'b0;
            rsp.result <= ~rsp.result;
            if (req.start) begin
                busy <= 1'b1;
                cnt <= delay;
                chan <= req.channel;
            end else if (busy && cnt == 8'h00) begin
                busy <= 1'b0;
                rsp.done <= 1'b1;
                rsp.result <= {chan, 8'h3C};
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : conv_core_model

// [tb/adc_control_status_upper_tb.sv]
`timescale 1ns/100ps
module adc_control_status_upper_tb;
    localparam logic [7:0] CSR = adc_ctrl_pkg::CSR_OFFSET;
    logic CORE_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic STANDBY = 1'b0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, CONV_END_IRQ, DMA_REQUEST, IRQ;
    adc_ctrl_pkg::core_req_t CORE_REQ;
    adc_ctrl_pkg::core_rsp_t CORE_RSP;
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int n_checks = 0;

    // 125 MHz clock
    always #4 CORE_CLK = ~CORE_CLK;

    adc_control_status_upper adc_control_status_upper_i (.CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .STANDBY(STANDBY), .CORE_REQ(CORE_REQ), .CORE_RSP(CORE_RSP),
        .CONV_END_IRQ(CONV_END_IRQ), .DMA_REQUEST(DMA_REQUEST), .IRQ(IRQ));
    conv_core_model conv_core_model_i (.clk(CORE_CLK), .rst_n(RESET_N), .delay(8'h14),
        .req(CORE_REQ), .rsp(CORE_RSP));

    task automatic stop_test();
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t level %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    // one apb transfer; request held until ready is sampled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        i = 0;
        do begin
            @(posedge CORE_CLK);
            i++;
        end while (PREADY !== 1'b1 && i < 16);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1) begin
            failures++;
            $display("MISMATCH %0t no ready", $time);
            stop_test();
        end
    endtask : apb

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check_word(rd, exp);
    endtask : rd_check

    // poll control/status until masked bits match
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        int i;
        i = 0;
        do begin
            apb(1'b0, CSR, 32'h0);
            i++;
        end while ((rd & m) !== v && i < 300);
        if ((rd & m) !== v) begin
            failures++;
            $display("MISMATCH %0t poll timeout", $time);
            stop_test();
        end
    endtask : poll

    task automatic settle();
        repeat (2) @(posedge CORE_CLK);
    endtask : settle

    initial begin
        repeat (4) @(posedge CORE_CLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        rd_check(CSR, 32'h0000_0040);
        rd_check(8'h04, 32'h0000_0000);
        // single mode, channel 2, interrupt enabled
        apb(1'b1, CSR, 32'h0000_6042);
        rd_check(CSR, 32'h0000_6042);
        poll(32'h0000_2000, 32'h0);
        check_word(rd, 32'h0000_C042);
        settle();
        check_bit(CONV_END_IRQ, 1'b1);
        check_bit(DMA_REQUEST, 1'b0);
        rd_check(8'h0C, 32'h0000_8F00);
        check_bit(IRQ, 1'b0);
        apb(1'b1, 8'h18, 32'h0000_0003);
        settle();
        check_bit(IRQ, 1'b1);
        apb(1'b1, 8'h14, 32'h0000_0003);
        settle();
        check_bit(IRQ, 1'b0);
        // flag: write one ignored, clear needs a read first
        apb(1'b1, CSR, 32'h0000_C042);
        apb(1'b1, CSR, 32'h0000_4042);
        rd_check(CSR, 32'h0000_C042);
        apb(1'b1, CSR, 32'h0000_0042);
        rd_check(CSR, 32'h0000_0042);
        // multi mode, channels 0 to 3, interrupt disabled
        apb(1'b1, CSR, 32'h0000_2063);
        rd_check(CSR, 32'h0000_2063);
        poll(32'h0000_2000, 32'h0);
        check_word(rd, 32'h0000_8063);
        settle();
        check_bit(CONV_END_IRQ, 1'b0);
        check_bit(IRQ, 1'b1);
        for (int c = 0; c < 4; c++) begin
            rd_check(8'h04 + 8'(4 * c), {16'h0, c[1:0], 8'h3C, 6'h00});
        end
        apb(1'b1, CSR, 32'h0000_0040);
        apb(1'b1, 8'h14, 32'h0000_0003);
        // dma route, result read clears the flag
        apb(1'b1, CSR, 32'h0000_7040);
        poll(32'h0000_2000, 32'h0);
        settle();
        check_bit(DMA_REQUEST, 1'b1);
        check_bit(CONV_END_IRQ, 1'b0);
        rd_check(8'h04, 32'h0000_0F00);
        settle();
        check_bit(DMA_REQUEST, 1'b0);
        rd_check(CSR, 32'h0000_5040);
        apb(1'b1, CSR, 32'h0000_0040);
        // scan mode keeps running past a pass, stops on a zero write
        apb(1'b1, CSR, 32'h0000_2071);
        poll(32'h0000_8000, 32'h0000_8000);
        check_bit(rd[13], 1'b1);
        apb(1'b1, CSR, 32'h0000_0071);
        rd_check(CSR, 32'h0000_0071);
        // standby ends a scan
        apb(1'b1, CSR, 32'h0000_2071);
        STANDBY <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        STANDBY <= 1'b0;
        apb(1'b0, CSR, 32'h0);
        check_bit(rd[13], 1'b0);
        // reset in mid-scan stops it and clears results
        apb(1'b1, CSR, 32'h0000_2071);
        repeat (30) @(posedge CORE_CLK);
        RESET_N <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        rd_check(CSR, 32'h0000_0040);
        rd_check(8'h04, 32'h0000_0000);
        check_bit(IRQ, 1'b0);
        // unmapped address
        apb(1'b0, 8'h1C, 32'h0);
        check_bit(err, 1'b1);
        check_word(rd, 32'h0);
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        check_bit(err, 1'b1);
        stop_test();
    end
endmodule : adc_control_status_upper_tb

bind adc_control_status_upper adc_csr_checker adc_csr_checker_i (.CORE_CLK(CORE_CLK),
    .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .STANDBY(STANDBY),
    .CORE_REQ(CORE_REQ), .CORE_RSP(CORE_RSP), .CONV_END_IRQ(CONV_END_IRQ),
    .DMA_REQUEST(DMA_REQUEST), .IRQ(IRQ));
